/* File: core/asm_pkg.sv */
package asm_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ASM_OFS_RIGHT_DIFF_MAG = 8'h6F;
    localparam logic [7:0] ASM_OFS_RIGHT_OFFSET = 8'h71;
    localparam logic [7:0] ASM_OFS_MUTE_LEVEL = 8'h72;
    localparam logic [7:0] ASM_OFS_RATE_MODE = 8'h73;
    localparam logic [7:0] ASM_OFS_BOOT_POWER = 8'h76;
    localparam logic [7:0] ASM_OFS_PIN_LEVEL = 8'h77;

    // ------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------
    localparam int ASM_SIGN_BIT = 7;
    localparam int ASM_CM_MAG_W = 5;
    localparam int ASM_DIFF_MAG_W = 8;
    localparam int ASM_MUTE_CODE_W = 2;
    localparam int ASM_RATE_W = 3;
    localparam int ASM_BOOT_BIT = 7;
    localparam int ASM_PSTATE_W = 4;
    localparam int ASM_GPIO2_BIT = 5;
    localparam int ASM_MUTE_PIN_BIT = 4;
    localparam int ASM_GPIO0_BIT = 3;

    // Writable reserved fields: masks within each register other than 0x6F
    localparam logic [7:0] ASM_RSV_MASK_RIGHT_OFFSET = 8'h60;
    localparam logic [7:0] ASM_RSV_MASK_MUTE_LEVEL = 8'hFC;
    localparam logic [7:0] ASM_RSV_MASK_RATE_MODE = 8'hF8;
    localparam logic [7:0] ASM_RSV_MASK_BOOT_POWER = 8'h70;
    localparam logic [7:0] ASM_RSV_MASK_PIN_LEVEL = 8'hC0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] ASM_RSV_RESET = 8'h00;
    localparam logic [7:0] ASM_RDATA_RESET = 8'h00;
    localparam logic [7:0] ASM_UNMAPPED_DATA = 8'h00;

    // ------------------------------------------------------------
    // Mute level decoder codes
    // ------------------------------------------------------------
    localparam logic [1:0] ASM_MUTE_HIGH = 2'h3;
    localparam logic [1:0] ASM_MUTE_MID = 2'h1;
    localparam logic [1:0] ASM_MUTE_LOW = 2'h0;

    // ------------------------------------------------------------
    // Rate mode codes
    // ------------------------------------------------------------
    localparam logic [2:0] ASM_RATE_AUTO_ERROR = 3'h0;
    localparam logic [2:0] ASM_RATE_AUTO_RSVD = 3'h7;
    localparam logic [2:0] ASM_RATE_REG_RSVD = 3'h0;
    localparam logic [2:0] ASM_RATE_REG_32K = 3'h7;

    // ------------------------------------------------------------
    // Power sequencing codes
    // ------------------------------------------------------------
    localparam logic [3:0] ASM_PS_POWERDOWN = 4'h0;
    localparam logic [3:0] ASM_PS_WAIT_CP = 4'h1;
    localparam logic [3:0] ASM_PS_CM_CAL = 4'h2;
    localparam logic [3:0] ASM_PS_DIFF_CAL = 4'h3;
    localparam logic [3:0] ASM_PS_RAMP_UP = 4'h4;
    localparam logic [3:0] ASM_PS_RUN = 4'h5;
    localparam logic [3:0] ASM_PS_SHORT = 4'h6;
    localparam logic [3:0] ASM_PS_RAMP_DOWN = 4'h7;
    localparam logic [3:0] ASM_PS_STANDBY = 4'h8;

    // Register access sequencer, one-hot
    typedef enum logic [1:0] {
        ASM_ACC_IDLE = 2'b01,
        ASM_ACC_ANSWER = 2'b10
    } asm_acc_e;

endpackage

/* File: core/asm_stat_if.sv */
`timescale 1ns/1ps
// Sampled monitor values passed from the capture stages to the register file
interface asm_stat_if;
    logic right_offset_sign;
    logic [7:0] right_diff_offset_mag;
    logic [4:0] right_cm_offset_mag;
    logic [1:0] mute_level_code;
    logic [2:0] rate_mode_monitor;
    logic rate_mode_fault;
    logic boot_done_flag;
    logic [3:0] power_seq_state;
    logic gpio_two_level;
    logic mute_pin;
    logic gpio_zero_level;

    modport capture (
        output right_offset_sign, right_diff_offset_mag, right_cm_offset_mag,
        output mute_level_code, boot_done_flag, power_seq_state,
        output gpio_two_level, mute_pin, gpio_zero_level
    );
    modport rate (
        output rate_mode_monitor, rate_mode_fault
    );
    modport regs (
        input right_offset_sign, right_diff_offset_mag, right_cm_offset_mag,
        input mute_level_code, rate_mode_monitor, rate_mode_fault,
        input boot_done_flag, power_seq_state,
        input gpio_two_level, mute_pin, gpio_zero_level
    );
endinterface

/* File: core/asm_capture.sv */
`timescale 1ns/1ps
module asm_capture
    import asm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_right_offset_sign,
    input wire logic [7:0] in_right_diff_offset_mag,
    input wire logic [4:0] in_right_cm_offset_mag,
    input wire logic [1:0] in_mute_level_code,
    input wire logic in_boot_done_flag,
    input wire logic [3:0] in_power_seq_state,
    input wire logic in_gpio_two_level,
    input wire logic in_mute_pin,
    input wire logic in_gpio_zero_level,
    asm_stat_if.capture stat
);

    typedef struct packed {
        logic sign;
        logic [7:0] diff_mag;
        logic [4:0] cm_mag;
        logic [1:0] mute_code;
        logic boot;
        logic [3:0] pstate;
        logic gpio2;
        logic mute;
        logic gpio0;
    } asm_cap_s;

    asm_cap_s st;
    asm_cap_s next_st;

    // ------------------------------------------------------------
    // Sampling of the internal monitor sources
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.sign = in_right_offset_sign;
        next_st.diff_mag = in_right_diff_offset_mag;
        next_st.cm_mag = in_right_cm_offset_mag;
        next_st.mute_code = in_mute_level_code;
        next_st.boot = in_boot_done_flag;
        next_st.pstate = in_power_seq_state;
        next_st.gpio2 = in_gpio_two_level;
        next_st.mute = in_mute_pin;
        next_st.gpio0 = in_gpio_zero_level;
    end

    // Reset shows powerdown, booting, all levels low
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign stat.right_offset_sign = st.sign;
    assign stat.right_diff_offset_mag = st.diff_mag;
    assign stat.right_cm_offset_mag = st.cm_mag;
    assign stat.mute_level_code = st.mute_code;
    assign stat.boot_done_flag = st.boot;
    assign stat.power_seq_state = st.pstate;
    assign stat.gpio_two_level = st.gpio2;
    assign stat.mute_pin = st.mute;
    assign stat.gpio_zero_level = st.gpio0;

endmodule

/* File: core/asm_rate_select.sv */
`timescale 1ns/1ps
module asm_rate_select
    import asm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clock_auto_set_en,
    input wire logic [2:0] auto_rate_mode,
    input wire logic [2:0] reg_rate_mode,
    asm_stat_if.rate stat
);

    typedef struct packed {
        logic [2:0] mode;
        logic fault;
    } asm_rate_s;

    asm_rate_s st;
    asm_rate_s next_st;

    // ------------------------------------------------------------
    // Source choice and invalid-code flag
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        if (clock_auto_set_en) begin
            next_st.mode = auto_rate_mode;
            next_st.fault = (auto_rate_mode == ASM_RATE_AUTO_ERROR) ||
                            (auto_rate_mode == ASM_RATE_AUTO_RSVD);
        end else begin
            next_st.mode = reg_rate_mode;
            next_st.fault = (reg_rate_mode == ASM_RATE_REG_RSVD);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign stat.rate_mode_monitor = st.mode;
    assign stat.rate_mode_fault = st.fault;

endmodule

/* File: core/asm_status_regs.sv */
`timescale 1ns/1ps
// Functional notes
// - Right offset register bit 7 reads pre-calibration offset polarity, 1 positive.
// - Right offset register bits 4-0 read common-feedback compensator final code.
// - Mute level register bits 1-0 read mute pin decoder band: 11, 01, 00.
// - Rate monitor shows detected mode when auto-set on, register mode otherwise.
// - Auto-set rate encoding; 000 means error and 111 is reserved.
// - Register-set rate encoding; 000 reserved, 111 means 32 kHz.
// - Boot/power register bit 7 reads 1 once processor boot completed.
// - Boot/power register bits 3-0 read the power sequencing state code.
// - Right offset magnitude readable as differential compensator code at 0x6F.
// - Pin level register bits 5,4,3 read GPIO2, mute pin, GPIO0 levels.
module asm_status_regs
    import asm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic reg_ready,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic right_offset_sign,
    input wire logic [7:0] right_diff_offset_mag,
    input wire logic [4:0] right_cm_offset_mag,
    input wire logic [1:0] mute_level_code,
    input wire logic clock_auto_set_en,
    input wire logic [2:0] auto_rate_mode,
    input wire logic [2:0] reg_rate_mode,
    input wire logic boot_done_flag,
    input wire logic [3:0] power_seq_state,
    input wire logic gpio_two_level,
    input wire logic mute_pin,
    input wire logic gpio_zero_level,
    output logic rate_mode_fault,
    output logic amp_running
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        asm_acc_e acc;
        logic [7:0] rsv_right_offset;
        logic [7:0] rsv_mute_level;
        logic [7:0] rsv_rate_mode;
        logic [7:0] rsv_boot_power;
        logic [7:0] rsv_pin_level;
        logic [7:0] rdata;
        logic rvalid;
        logic running;
    } asm_regs_s;

    asm_regs_s st;
    asm_regs_s next_st;
    logic [7:0] read_word;

    asm_stat_if stat ();

    // ------------------------------------------------------------
    // Capture stages
    // ------------------------------------------------------------
    // Registered copies of the internal monitor sources
    asm_capture u_capture (
        .clk(clk),
        .rst_n(rst_n),
        .in_right_offset_sign(right_offset_sign),
        .in_right_diff_offset_mag(right_diff_offset_mag),
        .in_right_cm_offset_mag(right_cm_offset_mag),
        .in_mute_level_code(mute_level_code),
        .in_boot_done_flag(boot_done_flag),
        .in_power_seq_state(power_seq_state),
        .in_gpio_two_level(gpio_two_level),
        .in_mute_pin(mute_pin),
        .in_gpio_zero_level(gpio_zero_level),
        .stat(stat.capture)
    );

    // Rate mode source selection
    asm_rate_select u_rate (
        .clk(clk),
        .rst_n(rst_n),
        .clock_auto_set_en(clock_auto_set_en),
        .auto_rate_mode(auto_rate_mode),
        .reg_rate_mode(reg_rate_mode),
        .stat(stat.rate)
    );

    // ------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------
    // Monitor bits come from the capture stages, reserved bits from storage
    always_comb begin
        read_word = ASM_UNMAPPED_DATA;
        case (reg_addr)
            ASM_OFS_RIGHT_DIFF_MAG: begin
                read_word = stat.right_diff_offset_mag;
            end
            ASM_OFS_RIGHT_OFFSET: begin
                read_word = st.rsv_right_offset & ASM_RSV_MASK_RIGHT_OFFSET;
                read_word[ASM_SIGN_BIT] = stat.right_offset_sign;
                read_word[ASM_CM_MAG_W-1:0] = stat.right_cm_offset_mag;
            end
            ASM_OFS_MUTE_LEVEL: begin
                read_word = st.rsv_mute_level & ASM_RSV_MASK_MUTE_LEVEL;
                read_word[ASM_MUTE_CODE_W-1:0] = stat.mute_level_code;
            end
            ASM_OFS_RATE_MODE: begin
                read_word = st.rsv_rate_mode & ASM_RSV_MASK_RATE_MODE;
                read_word[ASM_RATE_W-1:0] = stat.rate_mode_monitor;
            end
            ASM_OFS_BOOT_POWER: begin
                read_word = st.rsv_boot_power & ASM_RSV_MASK_BOOT_POWER;
                read_word[ASM_BOOT_BIT] = stat.boot_done_flag;
                read_word[ASM_PSTATE_W-1:0] = stat.power_seq_state;
            end
            ASM_OFS_PIN_LEVEL: begin
                read_word = st.rsv_pin_level & ASM_RSV_MASK_PIN_LEVEL;
                read_word[ASM_GPIO2_BIT] = stat.gpio_two_level;
                read_word[ASM_MUTE_PIN_BIT] = stat.mute_pin;
                read_word[ASM_GPIO0_BIT] = stat.gpio_zero_level;
            end
            default: begin
                read_word = ASM_UNMAPPED_DATA;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Access sequencer and reserved storage
    // ------------------------------------------------------------
    // A request is taken in IDLE; the answer cycle then returns to IDLE
    always_comb begin
        next_st = st;
        next_st.rvalid = 1'b0;
        next_st.running = (stat.power_seq_state == ASM_PS_RUN);
        case (st.acc)
            ASM_ACC_IDLE: begin
                if (reg_rd) begin
                    next_st.rdata = read_word;
                    next_st.rvalid = 1'b1;
                    next_st.acc = ASM_ACC_ANSWER;
                end else if (reg_wr) begin
                    // Only reserved bits take the write; monitor bits are untouched
                    case (reg_addr)
                        ASM_OFS_RIGHT_OFFSET: begin
                            next_st.rsv_right_offset =
                                reg_wdata & ASM_RSV_MASK_RIGHT_OFFSET;
                        end
                        ASM_OFS_MUTE_LEVEL: begin
                            next_st.rsv_mute_level =
                                reg_wdata & ASM_RSV_MASK_MUTE_LEVEL;
                        end
                        ASM_OFS_RATE_MODE: begin
                            next_st.rsv_rate_mode =
                                reg_wdata & ASM_RSV_MASK_RATE_MODE;
                        end
                        ASM_OFS_BOOT_POWER: begin
                            next_st.rsv_boot_power =
                                reg_wdata & ASM_RSV_MASK_BOOT_POWER;
                        end
                        ASM_OFS_PIN_LEVEL: begin
                            next_st.rsv_pin_level =
                                reg_wdata & ASM_RSV_MASK_PIN_LEVEL;
                        end
                        default: begin
                            next_st.acc = ASM_ACC_IDLE;
                        end
                    endcase
                    next_st.acc = ASM_ACC_ANSWER;
                end
            end
            ASM_ACC_ANSWER: begin
                next_st.acc = ASM_ACC_IDLE;
            end
            default: begin
                next_st.acc = ASM_ACC_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st.acc <= ASM_ACC_IDLE;
            st.rsv_right_offset <= ASM_RSV_RESET;
            st.rsv_mute_level <= ASM_RSV_RESET;
            st.rsv_rate_mode <= ASM_RSV_RESET;
            st.rsv_boot_power <= ASM_RSV_RESET;
            st.rsv_pin_level <= ASM_RSV_RESET;
            st.rdata <= ASM_RDATA_RESET;
            st.rvalid <= 1'b0;
            st.running <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_ready = (st.acc == ASM_ACC_IDLE); // Requests taken only in IDLE
    assign reg_rdata = st.rdata;
    assign reg_rvalid = st.rvalid;
    assign rate_mode_fault = stat.rate_mode_fault;
    assign amp_running = st.running;

endmodule

/* File: test/asm_status_regs_props.sv */
`timescale 1ns/1ps
module asm_status_chk
    import asm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_ready,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic right_offset_sign,
    input wire logic [7:0] right_diff_offset_mag,
    input wire logic [4:0] right_cm_offset_mag,
    input wire logic [1:0] mute_level_code,
    input wire logic clock_auto_set_en,
    input wire logic [2:0] auto_rate_mode,
    input wire logic [2:0] reg_rate_mode,
    input wire logic boot_done_flag,
    input wire logic [3:0] power_seq_state,
    input wire logic gpio_two_level,
    input wire logic mute_pin,
    input wire logic gpio_zero_level,
    input wire logic rate_mode_fault,
    input wire logic amp_running
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Read request taken at this edge
    logic take_rd;
    assign take_rd = reg_ready && reg_rd;

    // ------------------------------------------------------------
    // Register port timing
    // ------------------------------------------------------------
    chk_read_answer: assert property (take_rd |=> reg_rvalid && !reg_ready)
        else $error("read not answered in one cycle");
    chk_answer_cause: assert property (reg_rvalid |-> $past(take_rd))
        else $error("answer pulse without a read");
    chk_rdata_hold: assert property (!reg_rvalid && $past(rst_n) |-> $stable(reg_rdata))
        else $error("read data changed without an answer");

    // ------------------------------------------------------------
    // Monitor fields seen through reads, and the running flag
    // ------------------------------------------------------------
    chk_sign_read: assert property (take_rd && reg_addr == ASM_OFS_RIGHT_OFFSET
        && $stable(right_offset_sign) |=> reg_rdata[7] == $past(right_offset_sign))
        else $error("offset sign read wrong");
    chk_cm_mag_read: assert property (take_rd && reg_addr == ASM_OFS_RIGHT_OFFSET
        && $stable(right_cm_offset_mag) |=> reg_rdata[4:0] == $past(right_cm_offset_mag))
        else $error("common feedback magnitude read wrong");
    chk_mute_code_read: assert property (take_rd && reg_addr == ASM_OFS_MUTE_LEVEL
        && $stable(mute_level_code) |=> reg_rdata[1:0] == $past(mute_level_code))
        else $error("mute level code read wrong");
    chk_pstate_read: assert property (take_rd && reg_addr == ASM_OFS_BOOT_POWER
        && $stable(power_seq_state) |=> reg_rdata[3:0] == $past(power_seq_state))
        else $error("power state read wrong");
    chk_boot_read: assert property (take_rd && reg_addr == ASM_OFS_BOOT_POWER
        && $stable(boot_done_flag) |=> reg_rdata[7] == $past(boot_done_flag))
        else $error("boot flag read wrong");
    chk_pin_levels: assert property (take_rd && reg_addr == ASM_OFS_PIN_LEVEL
        && $stable({gpio_two_level, mute_pin, gpio_zero_level})
        |=> reg_rdata[5:0] == {$past({gpio_two_level, mute_pin, gpio_zero_level}), 3'h0})
        else $error("pin levels read wrong");
    chk_diff_mag_read: assert property (take_rd && reg_addr == ASM_OFS_RIGHT_DIFF_MAG
        && $stable(right_diff_offset_mag) |=> reg_rdata == $past(right_diff_offset_mag))
        else $error("differential magnitude read wrong");
    chk_amp_run_flag: assert property ($past(rst_n) && $past(rst_n, 2)
        |-> amp_running == ($past(power_seq_state, 2) == ASM_PS_RUN))
        else $error("running flag does not follow power state");

    // Main scenarios reached
    cov_rate_auto: cover property (take_rd && reg_addr == ASM_OFS_RATE_MODE && clock_auto_set_en);
    cov_write: cover property (reg_ready && reg_wr && !reg_rd);
    cov_running: cover property ($rose(amp_running));
endmodule

bind asm_status_regs asm_status_chk u_chk (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_ready(reg_ready), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .right_offset_sign(right_offset_sign), .right_diff_offset_mag(right_diff_offset_mag),
    .right_cm_offset_mag(right_cm_offset_mag), .mute_level_code(mute_level_code),
    .clock_auto_set_en(clock_auto_set_en), .auto_rate_mode(auto_rate_mode),
    .reg_rate_mode(reg_rate_mode), .boot_done_flag(boot_done_flag),
    .power_seq_state(power_seq_state), .gpio_two_level(gpio_two_level),
    .mute_pin(mute_pin), .gpio_zero_level(gpio_zero_level),
    .rate_mode_fault(rate_mode_fault), .amp_running(amp_running)
);

/* File: test/tb.sv */
`timescale 1ns/1ps
module tb
    import asm_pkg::*;
;
    logic clk, rst_n, reg_wr, reg_rd, reg_ready, reg_rvalid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, diff;
    logic sign, auto_en, boot, g2, mp, g0, rate_fault, amp_running;
    logic [4:0] cm;
    logic [1:0] mc;
    logic [2:0] auto_rate, reg_rate;
    logic [3:0] ps;
    logic [7:0] rsv [logic [7:0]];
    int errors, checks_done, cycles;

    asm_status_regs u_asm_status_regs (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_ready(reg_ready), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .right_offset_sign(sign), .right_diff_offset_mag(diff),
        .right_cm_offset_mag(cm), .mute_level_code(mc), .clock_auto_set_en(auto_en),
        .auto_rate_mode(auto_rate), .reg_rate_mode(reg_rate), .boot_done_flag(boot),
        .power_seq_state(ps), .gpio_two_level(g2), .mute_pin(mp), .gpio_zero_level(g0),
        .rate_mode_fault(rate_fault), .amp_running(amp_running)
    );

    // ------------------------------------------------------------
    // Clock and hang guard
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles > 5000) begin
            errors++;
            final_report();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        if (errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Waits at falling edges until the port can take a request
    task automatic wait_ready();
        int n;
        n = 0;
        while (reg_ready !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        wait_ready();
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        chk({7'h00, reg_rvalid}, 8'h01);
        d = reg_rdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        wait_ready();
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        if (rsv.exists(a)) begin
            rsv[a] = v & rsv_mask(a);
        end
    endtask

    function automatic logic [7:0] rsv_mask(input logic [7:0] a);
        case (a)
            ASM_OFS_RIGHT_OFFSET: return ASM_RSV_MASK_RIGHT_OFFSET;
            ASM_OFS_MUTE_LEVEL: return ASM_RSV_MASK_MUTE_LEVEL;
            ASM_OFS_RATE_MODE: return ASM_RSV_MASK_RATE_MODE;
            ASM_OFS_BOOT_POWER: return ASM_RSV_MASK_BOOT_POWER;
            default: return ASM_RSV_MASK_PIN_LEVEL;
        endcase
    endfunction

    // Expected read value built from the monitor inputs and stored reserved bits
    function automatic logic [7:0] expect_rd(input logic [7:0] a);
        logic [2:0] rate;
        rate = auto_en ? auto_rate : reg_rate;
        case (a)
            ASM_OFS_RIGHT_DIFF_MAG: return diff;
            ASM_OFS_RIGHT_OFFSET: return {sign, rsv[a][6:5], cm};
            ASM_OFS_MUTE_LEVEL: return {rsv[a][7:2], mc};
            ASM_OFS_RATE_MODE: return {rsv[a][7:3], rate};
            ASM_OFS_BOOT_POWER: return {boot, rsv[a][6:4], ps};
            ASM_OFS_PIN_LEVEL: return {rsv[a][7:6], g2, mp, g0, 3'h0};
            default: return ASM_UNMAPPED_DATA;
        endcase
    endfunction

    // Reads every mapped offset and one unmapped offset
    task automatic read_all();
        logic [7:0] d;
        foreach (rsv[a]) begin
            rd(a, d);
            chk(d, expect_rd(a));
        end
        rd(ASM_OFS_RIGHT_DIFF_MAG, d);
        chk(d, diff);
        rd(8'h80, d);
        chk(d, ASM_UNMAPPED_DATA);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_monitor_fields();
        logic [7:0] d;
        for (int i = 0; i <= 8; i++) begin
            sign = i[0];
            diff = {i[3:0], ~i[3:0]};
            cm = (i == 8) ? 5'h00 : 5'(31 - i);
            mc = (i % 3 == 0) ? ASM_MUTE_HIGH : ((i % 3 == 1) ? ASM_MUTE_MID : ASM_MUTE_LOW);
            boot = i[1];
            ps = 4'(i);
            {g2, mp, g0} = i[2:0];
            repeat (3) @(negedge clk);
            chk({7'h00, amp_running}, {7'h00, ps == ASM_PS_RUN});
            rd(ASM_OFS_RIGHT_OFFSET, d);
            chk(d, expect_rd(ASM_OFS_RIGHT_OFFSET));
            chk({3'h0, d[4:0]}, {3'h0, cm});
            rd(ASM_OFS_MUTE_LEVEL, d);
            chk(d, expect_rd(ASM_OFS_MUTE_LEVEL));
            rd(ASM_OFS_BOOT_POWER, d);
            chk(d, expect_rd(ASM_OFS_BOOT_POWER));
            chk({4'h0, d[3:0]}, {4'h0, ps});
            rd(ASM_OFS_PIN_LEVEL, d);
            chk(d, expect_rd(ASM_OFS_PIN_LEVEL));
            rd(ASM_OFS_RIGHT_DIFF_MAG, d);
            chk(d, diff);
        end
    endtask

    task automatic t_rate_mode();
        logic [7:0] d;
        for (int m = 0; m < 2; m++) begin
            for (int c = 0; c < 8; c++) begin
                auto_en = m[0];
                auto_rate = auto_en ? 3'(c) : 3'(7 - c);
                reg_rate = auto_en ? 3'(7 - c) : 3'(c);
                repeat (3) @(negedge clk);
                rd(ASM_OFS_RATE_MODE, d);
                if (auto_en) begin
                    chk({5'h00, d[2:0]}, {5'h00, auto_rate});
                    chk({7'h00, rate_fault}, {7'h00, c == 0 || c == 7});
                end else begin
                    chk({5'h00, d[2:0]}, {5'h00, reg_rate});
                    chk({7'h00, rate_fault}, {7'h00, c == 0});
                end
            end
        end
    endtask

    task automatic t_writes();
        foreach (rsv[a]) begin
            wr(a, 8'hFF);
        end
        wr(ASM_OFS_RIGHT_DIFF_MAG, 8'hA5);
        wr(8'h80, 8'hFF);
        read_all();
        foreach (rsv[a]) begin
            wr(a, 8'h00);
        end
        read_all();
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h00000;
        {sign, diff, cm, mc, boot, ps} = 21'h1A5F3A;
        {auto_en, auto_rate, reg_rate, g2, mp, g0} = 10'h15D;
        rsv[ASM_OFS_RIGHT_OFFSET] = ASM_RSV_RESET;
        rsv[ASM_OFS_MUTE_LEVEL] = ASM_RSV_RESET;
        rsv[ASM_OFS_RATE_MODE] = ASM_RSV_RESET;
        rsv[ASM_OFS_BOOT_POWER] = ASM_RSV_RESET;
        rsv[ASM_OFS_PIN_LEVEL] = ASM_RSV_RESET;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        read_all();
        t_monitor_fields();
        t_rate_mode();
        t_writes();
        final_report();
    end
endmodule
